// ===== src/ufafe_map.svh
// Constants for the user flash access front end
`ifndef UFAFE_MAP_SVH
`define UFAFE_MAP_SVH

// Clock period and figures in their own units
`define UFAFE_CLK_PERIOD_NS     5
`define UFAFE_REQ_MIN_NS        600
`define UFAFE_REQ_MAX_NS        3000
`define UFAFE_BUSY_MAX_NS       300
`define UFAFE_HOLD_MIN_NS       600

// Derived cycle counts: least times round up, longest round down
`define UFAFE_REQ_MIN_CYC  ((`UFAFE_REQ_MIN_NS + `UFAFE_CLK_PERIOD_NS - 1) / `UFAFE_CLK_PERIOD_NS)
`define UFAFE_REQ_MAX_CYC  (`UFAFE_REQ_MAX_NS / `UFAFE_CLK_PERIOD_NS)
`define UFAFE_BUSY_MAX_CYC (`UFAFE_BUSY_MAX_NS / `UFAFE_CLK_PERIOD_NS)
`define UFAFE_HOLD_MIN_CYC ((`UFAFE_HOLD_MIN_NS + `UFAFE_CLK_PERIOD_NS - 1) / `UFAFE_CLK_PERIOD_NS)

// Array geometry
`define UFAFE_WORDS            512
`define UFAFE_ADDR_W           9
`define UFAFE_DATA_W           16
`define UFAFE_SECTOR_WORDS     256

// Operation lengths inside the device, in cycles
`define UFAFE_READ_CYC         8
`define UFAFE_WRITE_CYC        16
`define UFAFE_ERASE_CYC        32

// Reset and padding values
`define UFAFE_ERASED_WORD      16'hFFFF
`define UFAFE_PAD_BYTE         8'hFF

`endif

// ===== src/ufafe_pkg.sv
// Types for the user flash access front end
package ufafe_pkg;
  typedef enum logic [1:0] {UFAFE_V1K, UFAFE_V2K, UFAFE_V4K, UFAFE_V8K}
    ufafe_view_type;
  typedef enum logic [1:0] {UFAFE_OP_NONE, UFAFE_OP_READ, UFAFE_OP_WRITE,
    UFAFE_OP_ERASE} ufafe_op_type;
endpackage

// ===== src/ufafe_if.sv
// Parallel request port between the flash front end and its user
`timescale 1ns/100ps
interface ufafe_if;
  logic        read_request_low;
  logic        write_request_low;
  logic        erase_request_low;
  logic [8:0]  word_pointer;
  logic [15:0] write_word_in;
  logic [15:0] read_word_out;
  logic        busy_low;
  logic        read_valid;

  modport device (
    input  read_request_low, write_request_low, erase_request_low,
    input  word_pointer, write_word_in,
    output read_word_out, busy_low, read_valid
  );
  modport host (
    output read_request_low, write_request_low, erase_request_low,
    output word_pointer, write_word_in,
    input  read_word_out, busy_low, read_valid
  );
endinterface

// ===== src/ufafe_host.sv
// Requesting end: turns one-cycle commands into timed request pulses
`timescale 1ns/100ps
`include "ufafe_map.svh"
module ufafe_host
  import ufafe_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // User command side
  input  wire ufafe_op_type cmd_op,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [8:0]  cmd_pointer,
  input  wire logic [15:0] cmd_data,
  output logic [15:0]      rd_data,
  output logic             rd_done,
  // Link to the device
  ufafe_if.host            link
);

  typedef enum logic [1:0] {UFAFE_H_IDLE, UFAFE_H_PULSE, UFAFE_H_WAIT}
    ufafe_hstate_type;

  localparam int PULSE_CYC = `UFAFE_REQ_MIN_CYC + 4;
  localparam int HOLD_CYC  = `UFAFE_HOLD_MIN_CYC + 4;

  ufafe_hstate_type state_r;
  ufafe_op_type     op_r;
  logic [9:0]       cnt_r;
  logic [8:0]       ptr_r;
  logic [15:0]      data_r;
  logic [15:0]      rd_data_r;
  logic             rd_done_r;

  // --------------------------------------------------------------
  // Request sequencing
  // --------------------------------------------------------------
  // New command only when device is not busy
  assign cmd_ready = (state_r == UFAFE_H_IDLE) && link.busy_low;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_r <= UFAFE_H_IDLE;
      op_r    <= UFAFE_OP_NONE;
      cnt_r   <= 10'h000;
      ptr_r   <= 9'h000;
      data_r  <= 16'h0000;
    end
    else
    begin
      case (state_r)
        UFAFE_H_IDLE:
        begin
          if (cmd_valid && cmd_ready && cmd_op != UFAFE_OP_NONE)
          begin
            op_r    <= cmd_op;
            ptr_r   <= cmd_pointer;
            data_r  <= cmd_data;
            cnt_r   <= 10'h000;
            state_r <= UFAFE_H_PULSE;
          end
        end
        UFAFE_H_PULSE:
        begin
          // Pulse length sits inside the legal window
          cnt_r <= cnt_r + 10'h001;
          if (cnt_r == 10'(PULSE_CYC - 1))
            state_r <= UFAFE_H_WAIT;
        end
        UFAFE_H_WAIT:
        begin
          cnt_r <= cnt_r + 10'h001;
          // Keep pointer stable past hold time, then wait for idle
          if (cnt_r >= 10'(HOLD_CYC) && link.busy_low)
          begin
            op_r    <= UFAFE_OP_NONE;
            state_r <= UFAFE_H_IDLE;
          end
        end
        default:
          state_r <= UFAFE_H_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Pin drive
  // --------------------------------------------------------------
  // One line at a time, low means request
  always_comb
  begin
    link.read_request_low  = 1'b1;
    link.write_request_low = 1'b1;
    link.erase_request_low = 1'b1;
    if (state_r == UFAFE_H_PULSE)
    begin
      link.read_request_low  = (op_r != UFAFE_OP_READ);
      link.write_request_low = (op_r != UFAFE_OP_WRITE);
      link.erase_request_low = (op_r != UFAFE_OP_ERASE);
    end
  end

  assign link.word_pointer  = ptr_r;
  assign link.write_word_in = data_r;

  // --------------------------------------------------------------
  // Read return
  // --------------------------------------------------------------
  // Capture once the device reports a finished read
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rd_data_r <= 16'h0000;
      rd_done_r <= 1'b0;
    end
    else
    begin
      rd_done_r <= 1'b0;
      if (state_r == UFAFE_H_WAIT && op_r == UFAFE_OP_READ &&
          cnt_r >= 10'(HOLD_CYC) && link.busy_low && link.read_valid)
      begin
        rd_data_r <= link.read_word_out;
        rd_done_r <= 1'b1;
      end
    end
  end

  assign rd_data = rd_data_r;
  assign rd_done = rd_done_r;

endmodule

// ===== src/ufafe_device.sv
// Device end: flash array, request decode, byte view translation
//--------------------------------------------------------------------
// Functional notes
// - Request lines are active low
// - Requester holds request 600 to 3000 ns
// - Busy falls within 300 ns of request
// - Pointer and data stable 600 ns after request
// - Oscillator runs with write access, else off
// - Array is 512 words of 16 bits
// - Byte views of 128, 256, 512, 1024 bytes
// - Smallest view: upper half maps to 1C0h
// - 2 Kbit view: upper half maps to 180h
// - 4 Kbit view maps one to one
// - 8 Kbit view uses every array location
// - Byte in upper half, low byte ones
// - Narrow data in MSBs, LSBs ones
// - Unused words should be all ones
// - Base serial view uses sector 0 only
// - Built-in serial port has 13 signals
// - Busy low for the whole operation
// - Read valid high after read finishes
// - Simultaneous requests are ignored entirely
// - Erase clears sector chosen by pointer MSB
//--------------------------------------------------------------------
`timescale 1ns/100ps
`include "ufafe_map.svh"
module ufafe_device
  import ufafe_pkg::*;
#(
  parameter bit WRITE_ACCESS = 1'b1,
  parameter int DATA_WIDTH   = 16
)
(
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           sys_rst,
  // Parallel port
  ufafe_if.device             link,
  // Byte view, translation only
  input  wire ufafe_view_type view_size,
  input  wire logic [9:0]     byte_addr,
  input  wire logic [7:0]     byte_in,
  output logic [8:0]          view_word_ptr,
  output logic [15:0]         view_word_in,
  output logic [7:0]          view_byte_out,
  // Oscillator and built-in serial port status
  output logic                osc_enable,
  output logic [3:0]          serial_port_pins
);

  typedef enum logic [1:0] {UFAFE_D_IDLE, UFAFE_D_RUN, UFAFE_D_RELEASE}
    ufafe_dstate_type;

  localparam int PAD_W = `UFAFE_DATA_W - DATA_WIDTH;

  logic [15:0]      mem_r [`UFAFE_WORDS];
  ufafe_dstate_type state_r;
  ufafe_op_type     op_r;
  logic [8:0]       ptr_r;
  logic [15:0]      wdata_r;
  logic [5:0]       cnt_r;
  logic [15:0]      rdata_r;
  logic             valid_r;
  logic             rd_l_r, wr_l_r, er_l_r;
  logic             rd_fall, wr_fall, er_fall;
  logic [2:0]       low_cnt;
  logic             busy_l;
  logic             done;
  logic [15:0]      padded;

  // --------------------------------------------------------------
  // Request decode
  // --------------------------------------------------------------
  // Falling edges of the active-low request lines
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rd_l_r <= 1'b1;
      wr_l_r <= 1'b1;
      er_l_r <= 1'b1;
    end
    else
    begin
      rd_l_r <= link.read_request_low;
      wr_l_r <= link.write_request_low;
      er_l_r <= link.erase_request_low;
    end
  end

  assign rd_fall = rd_l_r && !link.read_request_low;
  assign wr_fall = wr_l_r && !link.write_request_low;
  assign er_fall = er_l_r && !link.erase_request_low;
  // Count lines held low; more than one means conflict
  assign low_cnt = 3'(!link.read_request_low) + 3'(!link.write_request_low)
                 + 3'(!link.erase_request_low);

  // Narrow write data gets ones below it
  assign padded = (PAD_W == 0) ? link.write_word_in :
    (link.write_word_in | 16'((17'h1_0000 >> DATA_WIDTH) - 17'h0_0001));

  // --------------------------------------------------------------
  // Operation sequencer
  // --------------------------------------------------------------
  // Pointer and data are taken at the edge itself
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_r <= UFAFE_D_IDLE;
      op_r    <= UFAFE_OP_NONE;
      ptr_r   <= 9'h000;
      wdata_r <= 16'h0000;
      cnt_r   <= 6'h00;
    end
    else
    begin
      case (state_r)
        UFAFE_D_IDLE:
        begin
          if ((rd_fall || wr_fall || er_fall) && low_cnt == 3'd1)
          begin
            // Read-only build ignores write and erase
            if (rd_fall || WRITE_ACCESS)
            begin
              op_r    <= rd_fall ? UFAFE_OP_READ :
                         wr_fall ? UFAFE_OP_WRITE : UFAFE_OP_ERASE;
              ptr_r   <= link.word_pointer;
              wdata_r <= padded;
              cnt_r   <= 6'h00;
              state_r <= UFAFE_D_RUN;
            end
          end
        end
        UFAFE_D_RUN:
        begin
          cnt_r <= cnt_r + 6'h01;
          if (done)
            state_r <= UFAFE_D_RELEASE;
        end
        UFAFE_D_RELEASE:
        begin
          // Wait for line release so one pulse is one operation
          if (low_cnt == 3'd0)
            state_r <= UFAFE_D_IDLE;
        end
        default:
          state_r <= UFAFE_D_IDLE;
      endcase
    end
  end

  always_comb
  begin
    case (op_r)
      UFAFE_OP_READ:  done = (cnt_r == 6'(`UFAFE_READ_CYC - 1));
      UFAFE_OP_WRITE: done = (cnt_r == 6'(`UFAFE_WRITE_CYC - 1));
      UFAFE_OP_ERASE: done = (cnt_r == 6'(`UFAFE_ERASE_CYC - 1));
      default:        done = 1'b1;
    endcase
  end

  // --------------------------------------------------------------
  // Array storage
  // --------------------------------------------------------------
  // Erase selects sector by pointer MSB; write stores padded word
  for (genvar i = 0; i < `UFAFE_WORDS; i++)
  begin : g_word
    always_ff @(posedge clk)
    begin
      if (sys_rst)
        mem_r[i] <= `UFAFE_ERASED_WORD;
      else if (state_r == UFAFE_D_RUN && done)
      begin
        if (op_r == UFAFE_OP_WRITE && ptr_r == 9'(i))
          mem_r[i] <= wdata_r;
        else if (op_r == UFAFE_OP_ERASE && ptr_r[8] == 1'(i >> 8))
          mem_r[i] <= `UFAFE_ERASED_WORD;
      end
    end
  end

  // --------------------------------------------------------------
  // Read data and valid flag
  // --------------------------------------------------------------
  // Valid drops when a new read starts, rises when it ends
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rdata_r <= `UFAFE_ERASED_WORD;
      valid_r <= 1'b0;
    end
    // Cleared at the taking edge so a stale flag never overlaps a new run
    else if (state_r == UFAFE_D_IDLE && rd_fall && low_cnt == 3'd1)
      valid_r <= 1'b0;
    else if (state_r == UFAFE_D_RUN && op_r == UFAFE_OP_READ)
    begin
      valid_r <= done;
      if (done)
        rdata_r <= mem_r[ptr_r];
    end
  end

  // Busy follows the request edge in the same cycle
  assign busy_l = !((state_r == UFAFE_D_IDLE && low_cnt == 3'd1 &&
                     (rd_fall || (WRITE_ACCESS && (wr_fall || er_fall))))
                    || state_r == UFAFE_D_RUN);

  assign link.busy_low      = busy_l;
  assign link.read_valid    = valid_r;
  assign link.read_word_out = rdata_r;

  // --------------------------------------------------------------
  // Byte view translation
  // --------------------------------------------------------------
  // No clock in this path, so no added latency
  always_comb
  begin
    view_word_ptr = 9'h000;
    case (view_size)
      UFAFE_V1K:
        view_word_ptr = byte_addr[6] ? {3'b111, byte_addr[5:0]}
                                     : {3'b000, byte_addr[5:0]};
      UFAFE_V2K:
        view_word_ptr = byte_addr[7] ? {2'b11, byte_addr[6:0]}
                                     : {2'b00, byte_addr[6:0]};
      UFAFE_V4K:
        view_word_ptr = byte_addr[8:0];
      UFAFE_V8K:
        view_word_ptr = byte_addr[9:1];
      default:
        view_word_ptr = 9'h000;
    endcase
  end

  // Byte sits high, low half padded with ones; 8K reads use both halves
  assign view_word_in  = {byte_in, `UFAFE_PAD_BYTE};
  assign view_byte_out = (view_size == UFAFE_V8K && !byte_addr[0]) ?
                         rdata_r[7:0] : rdata_r[15:8];

  // Oscillator follows the build's access mode
  assign osc_enable       = WRITE_ACCESS;
  assign serial_port_pins = 4'd13;

endmodule

// ===== tb/ufafe_monitor.sv
// Checker of the parallel request port between host and device
`timescale 1ns/100ps
`include "ufafe_map.svh"
module ufafe_monitor
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Request side
  input wire logic        read_request_low,
  input wire logic        write_request_low,
  input wire logic        erase_request_low,
  input wire logic [8:0]  word_pointer,
  input wire logic [15:0] write_word_in,
  // Answer side
  input wire logic        busy_low,
  input wire logic        read_valid
);
  //------------------------------------------------------------
  // Common timing
  //------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  //------------------------------------------------------------
  // Helper counters
  //------------------------------------------------------------
  localparam logic [10:0] REQ_MIN  = 11'(`UFAFE_REQ_MIN_CYC);
  localparam logic [10:0] REQ_MAX  = 11'(`UFAFE_REQ_MAX_CYC);
  localparam logic [7:0]  HOLD_MIN = 8'(`UFAFE_HOLD_MIN_CYC);

  logic        any_low;
  logic        any_low_r;
  logic [10:0] low_run_r;
  logic [7:0]  since_req_r;

  assign any_low = !(read_request_low && write_request_low &&
                     erase_request_low);

  // Length of the read pulse; saturates so a stuck line still reads long
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      low_run_r <= 11'h000;
    else if (read_request_low)
      low_run_r <= 11'h000;
    else if (low_run_r != 11'h7ff)
      low_run_r <= low_run_r + 11'h001;
  end

  // Cycles since the last request edge, too long to unroll in a property
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      any_low_r   <= 1'b0;
      since_req_r <= 8'hff;
    end
    else
    begin
      any_low_r <= any_low;
      if (any_low && !any_low_r)
        since_req_r <= 8'h00;
      else if (since_req_r != 8'hff)
        since_req_r <= since_req_r + 8'h01;
    end
  end

  // Any request line falling
  sequence s_req_fell;
    $fell(read_request_low) || $fell(write_request_low) ||
    $fell(erase_request_low);
  endsequence

  // Read run: flag drops, then returns within 1 to 20 cycles
  sequence s_read_run;
    !read_valid ##[1:20] read_valid;
  endsequence

  //------------------------------------------------------------
  // Port assertions
  //------------------------------------------------------------
  busy_fall_a:
    assert property ($fell(read_request_low) && write_request_low &&
      erase_request_low && $past(busy_low) |-> !busy_low)
    else $error("busy did not fall on read request");
  busy_cause_a:
    assert property ($fell(busy_low) |-> s_req_fell)
    else $error("busy fell without a request edge");
  busy_hold_a:
    assert property ($fell(busy_low) |-> !busy_low [*8])
    else $error("busy released during the run");
  busy_bound_a:
    assert property ($fell(busy_low) |-> ##[8:40] busy_low)
    else $error("busy never released");
  run_length_a:
    assert property ($rose(busy_low) |-> !$past(busy_low, 8))
    else $error("busy run too short");
  read_done_a:
    assert property ($fell(busy_low) && !read_request_low |=> s_read_run)
    else $error("read valid sequence wrong");
  valid_hold_a:
    assert property (read_valid && read_request_low |=> read_valid)
    else $error("read valid dropped without a read");
  req_width_a:
    assert property ($rose(read_request_low) |->
      low_run_r >= REQ_MIN && low_run_r <= REQ_MAX)
    else $error("read request width out of range");
  ptr_hold_a:
    assert property (($changed(word_pointer) || $changed(write_word_in))
      |-> since_req_r >= HOLD_MIN)
    else $error("pointer or data moved during request");
endmodule

// ===== tb/test_user_flash_access_front_end.sv
// Testbench of the flash front end, host and device back to back
`timescale 1ns/100ps
module test_user_flash_access_front_end
  import ufafe_pkg::*;
;
  logic           clk;
  logic           sys_rst;
  ufafe_op_type   cmd_op;
  logic           cmd_valid;
  logic           cmd_ready;
  logic [8:0]     cmd_pointer;
  logic [15:0]    cmd_data;
  logic [15:0]    rd_data;
  logic           rd_done;
  ufafe_view_type view_size;
  logic [9:0]     byte_addr;
  logic [7:0]     byte_in;
  logic [8:0]     view_word_ptr;
  logic [15:0]    view_word_in;
  logic           osc_enable;
  logic [3:0]     serial_port_pins;
  logic [7:0]     view_byte_out;
  logic           osc_ro;
  logic           b3;
  logic [15:0]    got;
  logic           b2;
  int             fails;
  int             total_checks;
  int             cyc;

  //------------------------------------------------------------
  // Design under test
  //------------------------------------------------------------
  ufafe_if lnk ();
  ufafe_if lnk2 ();
  ufafe_if lnk3 ();
  ufafe_host ufafe_host_inst (.clk(clk), .sys_rst(sys_rst),
    .cmd_op(cmd_op), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_pointer(cmd_pointer), .cmd_data(cmd_data), .rd_data(rd_data),
    .rd_done(rd_done), .link(lnk.host));
  ufafe_device ufafe_device_inst (.clk(clk), .sys_rst(sys_rst),
    .link(lnk.device), .view_size(view_size), .byte_addr(byte_addr),
    .byte_in(byte_in), .view_word_ptr(view_word_ptr),
    .view_word_in(view_word_in), .view_byte_out(view_byte_out),
    .osc_enable(osc_enable), .serial_port_pins(serial_port_pins));
  // Narrow build on a second port, driven directly to break the rules
  ufafe_device #(.DATA_WIDTH(8)) ufafe_device_narrow_inst (.clk(clk),
    .sys_rst(sys_rst), .link(lnk2.device), .view_size(UFAFE_V1K),
    .byte_addr(10'h000), .byte_in(8'h00), .view_word_ptr(),
    .view_word_in(), .view_byte_out(), .osc_enable(),
    .serial_port_pins());
  // Read-only build, fed the same request lines as the narrow port
  ufafe_device #(.WRITE_ACCESS(1'b0)) ufafe_device_ro_inst (.clk(clk),
    .sys_rst(sys_rst), .link(lnk3.device), .view_size(UFAFE_V1K),
    .byte_addr(10'h000), .byte_in(8'h00), .view_word_ptr(),
    .view_word_in(), .view_byte_out(), .osc_enable(osc_ro),
    .serial_port_pins());
  assign lnk3.read_request_low  = lnk2.read_request_low;
  assign lnk3.write_request_low = lnk2.write_request_low;
  assign lnk3.erase_request_low = lnk2.erase_request_low;
  assign lnk3.word_pointer      = lnk2.word_pointer;
  assign lnk3.write_word_in     = lnk2.write_word_in;
  ufafe_monitor ufafe_monitor_inst (.clk(clk), .sys_rst(sys_rst),
    .read_request_low(lnk.read_request_low),
    .write_request_low(lnk.write_request_low),
    .erase_request_low(lnk.erase_request_low),
    .word_pointer(lnk.word_pointer), .write_word_in(lnk.write_word_in),
    .busy_low(lnk.busy_low), .read_valid(lnk.read_valid));

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // Hang guard, well above the expected few thousand cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 12000)
    begin
      fails++;
      stop_test();
    end
  end

  //------------------------------------------------------------
  // Shared tasks
  //------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One host command; waits until the host is free again
  task automatic op(input ufafe_op_type o, input logic [8:0] p,
                    input logic [15:0] d);
    int n;
    @(posedge clk);
    cmd_op <= o;
    cmd_pointer <= p;
    cmd_data <= d;
    cmd_valid <= 1'b1;
    n = 0;
    do @(posedge clk); while (cmd_ready !== 1'b1 && n++ < 400);
    cmd_valid <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk);
      if (rd_done === 1'b1)
        got = rd_data;
    end
    while (cmd_ready !== 1'b1 && n++ < 400);
  endtask

  task automatic rd(input logic [8:0] p, input logic [15:0] exp);
    got = ~exp;
    op(UFAFE_OP_READ, p, 16'h0000);
    chk("read word", got, exp);
  endtask

  // Request pulse of 124 cycles on the second port
  task automatic pulse2(input logic r, input logic w);
    int n;
    @(posedge clk);
    lnk2.read_request_low <= r;
    lnk2.write_request_low <= w;
    repeat (4) @(posedge clk);
    b2 = lnk2.busy_low;
    b3 = lnk3.busy_low;
    repeat (120) @(posedge clk);
    lnk2.read_request_low <= 1'b1;
    lnk2.write_request_low <= 1'b1;
    n = 0;
    do @(posedge clk); while (lnk2.busy_low !== 1'b1 && n++ < 100);
  endtask

  //------------------------------------------------------------
  // Scenarios
  //------------------------------------------------------------
  task automatic t_reset;
    @(posedge clk);
    chk("busy idle", 16'(lnk.busy_low), 16'h0001);
    chk("valid idle", 16'(lnk.read_valid), 16'h0000);
    chk("osc enable", 16'(osc_enable), 16'h0001);
    chk("osc read only", 16'(osc_ro), 16'h0000);
    chk("serial pins", 16'(serial_port_pins), 16'h000d);
    rd(9'h1ff, 16'hffff);
    $display("test reset done");
  endtask

  task automatic t_write;
    op(UFAFE_OP_WRITE, 9'h000, 16'h1234);
    op(UFAFE_OP_WRITE, 9'h1ff, 16'habcd);
    op(UFAFE_OP_WRITE, 9'h0ff, 16'h5a5a);
    rd(9'h000, 16'h1234);
    rd(9'h1ff, 16'habcd);
    chk("valid", 16'(lnk.read_valid), 16'h0001);
    chk("word out", lnk.read_word_out, 16'habcd);
    chk("view byte high", 16'(view_byte_out), 16'h00ab);
    @(posedge clk);
    view_size <= UFAFE_V8K;
    byte_addr <= 10'h200;
    #1;
    chk("view byte low", 16'(view_byte_out), 16'h00cd);
    $display("test write done");
  endtask

  // Sector one first, so sector zero must survive it
  task automatic t_erase;
    op(UFAFE_OP_ERASE, 9'h100, 16'h0000);
    rd(9'h1ff, 16'hffff);
    rd(9'h0ff, 16'h5a5a);
    op(UFAFE_OP_ERASE, 9'h0ff, 16'h0000);
    rd(9'h000, 16'hffff);
    $display("test erase done");
  endtask

  // Boundaries of every view size, checked 1 ns after each edge that applies them, before the next edge
  task t_view;
    ufafe_view_type vs [10] = '{UFAFE_V1K, UFAFE_V1K, UFAFE_V1K,
      UFAFE_V2K, UFAFE_V2K, UFAFE_V2K, UFAFE_V4K, UFAFE_V4K,
      UFAFE_V8K, UFAFE_V8K};
    logic [9:0] ba [10] = '{10'h03f, 10'h040, 10'h07f, 10'h07f,
      10'h080, 10'h0ff, 10'h0ff, 10'h100, 10'h3ff, 10'h200};
    logic [8:0] wp [10] = '{9'h03f, 9'h1c0, 9'h1ff, 9'h07f, 9'h180,
      9'h1ff, 9'h0ff, 9'h100, 9'h1ff, 9'h100};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk);
      view_size <= vs[i];
      byte_addr <= ba[i];
      byte_in <= 8'h3c ^ 8'(i);
      #1;
      chk("view ptr", 16'(view_word_ptr), 16'(wp[i]));
      chk("view word", view_word_in, {8'h3c ^ 8'(i), 8'hff});
    end
    $display("test view done");
  endtask

  task automatic t_narrow;
    pulse2(1'b0, 1'b0);
    chk("busy refused", 16'(b2), 16'h0001);
    pulse2(1'b0, 1'b1);
    chk("refused write", lnk2.read_word_out, 16'hffff);
    pulse2(1'b1, 1'b0);
    chk("busy write", 16'(b2), 16'h0000);
    chk("read only write", 16'(b3), 16'h0001);
    pulse2(1'b0, 1'b1);
    chk("narrow word", lnk2.read_word_out, 16'h5aff);
    chk("read only busy", 16'(b3), 16'h0000);
    chk("read only word", lnk3.read_word_out, 16'hffff);
    $display("test narrow done");
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    cmd_op = UFAFE_OP_NONE;
    cmd_valid = 1'b0;
    cmd_pointer = 9'h000;
    cmd_data = 16'h0000;
    view_size = UFAFE_V1K;
    byte_addr = 10'h000;
    byte_in = 8'h00;
    lnk2.read_request_low = 1'b1;
    lnk2.write_request_low = 1'b1;
    lnk2.erase_request_low = 1'b1;
    lnk2.word_pointer = 9'h010;
    lnk2.write_word_in = 16'h5a5a;
    fails = 0;
    total_checks = 0;
    cyc = 0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_write();
    t_erase();
    t_view();
    t_narrow();
    stop_test();
  end
endmodule
